// [rbx_regs.svh]
// Register offsets, field positions, opcodes and phase codes of the executor.
`ifndef RBX_REGS_SVH
`define RBX_REGS_SVH

// Width of the program counter in bits.
`define RBX_PC_W        21

// Wishbone byte offsets of the register words.
`define RBX_ADDR_CTRL   8'h00
`define RBX_ADDR_STATUS 8'h04
`define RBX_ADDR_PC     8'h08
`define RBX_ADDR_COUNT  8'h0C

// Control word fields and reset value.
`define RBX_CTRL_RUN    0
`define RBX_CTRL_RST    1'h0

// Status word field positions.
`define RBX_ST_NOP_BIT  0
`define RBX_ST_TAKEN    1
`define RBX_ST_OP_LSB   2
`define RBX_ST_Q_LSB    5

// Reset value of the program counter.
`define RBX_PC_RST      21'h000000

// Opcode patterns of the decoded instructions.
`define RBX_OP_BOV      8'hE5
`define RBX_OP_BZ       8'hE1
`define RBX_OP_BRA      5'h1A
`define RBX_OP_BSF      4'h8

// Phases of the four-clock instruction cycle.
`define RBX_Q1          2'h0
`define RBX_Q2          2'h1
`define RBX_Q3          2'h2
`define RBX_Q4          2'h3

// Access bank layout: low half maps to bank 0, upper half to the top bank.
`define RBX_ACC_SPLIT   8'h80
`define RBX_ACC_HIBANK  4'hF

`endif

// [rbx_pkg.sv]
// Types shared by the branch and bit-set executor.
`include "rbx_regs.svh"

package rbx_pkg;

	// Instruction cycle kind: executing or the flushed second cycle.
	typedef enum logic [0:0] {
		RBX_ST_EXEC = 1'b0,
		RBX_ST_NOP  = 1'b1
	} rbx_st_t;

	// Decoded instruction class.
	typedef enum logic [2:0] {
		RBX_OP_NONE = 3'h0,
		RBX_OP_BOVC = 3'h1,
		RBX_OP_BZC  = 3'h2,
		RBX_OP_BRAU = 3'h3,
		RBX_OP_SETB = 3'h4
	} rbx_op_t;

	// Data register file access port.
	typedef struct packed {
		logic [11:0] addr;
		logic        re;
		logic        we;
		logic [7:0]  wdata;
	} rbx_file_t;

	// Whole state of the executor.
	typedef struct packed {
		logic [1:0]              q;
		rbx_st_t                 st;
		logic                    run;
		logic [`RBX_PC_W-1:0]    pc;
		logic [`RBX_PC_W-1:0]    tgt;
		logic [15:0]             ir;
		rbx_op_t                 op;
		logic                    taken;
		rbx_file_t               file;
		logic [15:0]             count;
		logic                    ack;
		logic [31:0]             dat;
	} rbx_state_t;

endpackage

// [rbx_exec.sv]
// Branch and bit-set instruction executor with a Wishbone register slave.
`timescale 1ns/1ns
`include "rbx_regs.svh"

// Contract
// - Upper byte E5 branches when overflow clear.
// - Taken target is incremented PC plus 2n.
// - Upper byte E1 branches when zero clear.
// - Conditional branch: one cycle, two if taken.
// - Decode, read, compute, load PC; then nop.
// - Upper bits 11010 always branch, 11-bit offset.
// - Unconditional branch takes two cycles always.
// - Upper nibble 1000 sets selected file bit.
// - Bank bit 0 uses access bank, else bank select.
// - Bit set reads Q2, modifies Q3, writes Q4.
// - No status flag is ever changed.
module rbx_exec
	import rbx_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	// Wishbone classic slave.
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Program memory fetch path.
	output logic      [`RBX_PC_W-1:0] pc_o,
	input  wire logic [15:0]          instr_i,
	// Status flags and bank select from the surrounding core.
	input  wire logic                 ovf_flag_i,
	input  wire logic                 zero_flag_i,
	input  wire logic [3:0]           bank_select_register_i,
	// Banked data register file.
	output rbx_file_t                 file_o,
	input  wire logic [7:0]           file_rdata_i,
	// Current instruction phase, zero meaning Q1.
	output logic      [1:0]           q_phase_o
);

	rbx_state_t s_ff;      // Registered state.
	rbx_state_t nxt_s;     // Next state.

	// Classifies an instruction word; anything else is left to other units.
	function automatic rbx_op_t rbx_decode(input logic [15:0] w);
		rbx_op_t r;
		r = RBX_OP_NONE;
		if (w[15:8] == `RBX_OP_BOV) begin
			r = RBX_OP_BOVC;
		end else if (w[15:8] == `RBX_OP_BZ) begin
			r = RBX_OP_BZC;
		end else if (w[15:11] == `RBX_OP_BRA) begin
			r = RBX_OP_BRAU;
		end else if (w[15:12] == `RBX_OP_BSF) begin
			r = RBX_OP_SETB;
		end
		return r;
	endfunction

	// Builds the file address from the bank mode bit and the 8-bit field.
	function automatic logic [11:0] rbx_faddr(input logic [15:0] w,
	                                          input logic [3:0]  bsel);
		logic [11:0] a;
		a = {bsel, w[7:0]};
		if (!w[8]) begin
			// Access bank ignores the bank select value entirely.
			if (w[7:0] < `RBX_ACC_SPLIT) begin
				a = {4'h0, w[7:0]};
			end else begin
				a = {`RBX_ACC_HIBANK, w[7:0]};
			end
		end
		return a;
	endfunction

	// Merges the selected byte lanes of a Wishbone write into a stored word.
	function automatic logic [31:0] rbx_merge(input logic [31:0] old,
	                                          input logic [31:0] wd,
	                                          input logic [3:0]  sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction

	logic [`RBX_PC_W-1:0] off2;     // Doubled, sign-extended offset.
	logic                 cond;     // Branch condition of the held word.
	logic [7:0]           setmask;  // One-hot mask of the bit to set.
	logic [31:0]          pcword;   // Program counter as a bus word.
	logic [31:0]          pcnew;    // Program counter after a bus write.
	logic                 bus_go;   // New bus request this cycle.

	// Offset, condition and mask of the held instruction word.
	always_comb begin
		// The doubling is a shift of the sign-extended literal, so negative
		// offsets stay two's complement across the whole counter width.
		if (s_ff.op == RBX_OP_BRAU) begin
			off2 = {{(`RBX_PC_W-12){s_ff.ir[10]}},
			        s_ff.ir[10:0], 1'b0};
		end else begin
			off2 = {{(`RBX_PC_W-9){s_ff.ir[7]}},
			        s_ff.ir[7:0], 1'b0};
		end
		// Flags are only sampled here and never driven by this unit.
		case (s_ff.op)
			RBX_OP_BOVC: cond = !ovf_flag_i;
			RBX_OP_BZC:  cond = !zero_flag_i;
			RBX_OP_BRAU: cond = 1'b1;
			default:     cond = 1'b0;
		endcase
		setmask = 8'h01 << s_ff.ir[11:9];
		pcword = 32'h0000_0000;
		pcword[`RBX_PC_W-1:0] = s_ff.pc;
		pcnew = rbx_merge(pcword, wb_dat_i, wb_sel_i);
		bus_go = wb_cyc_i && wb_stb_i && !s_ff.ack;
	end

	// Next state: the instruction cycle sequencer and the register slave.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.file.we = 1'b0;

		// Four phases per instruction cycle; while stopped the sequencer
		// parks in Q1 of an executing cycle and fetches nothing.
		case (s_ff.q)
			`RBX_Q1: begin
				if (s_ff.st == RBX_ST_NOP) begin
					// Flushed cycle: the prefetched word is dropped.
					nxt_s.op = RBX_OP_NONE;
					nxt_s.q = `RBX_Q2;
				end else if (s_ff.run) begin
					nxt_s.ir = instr_i;
					nxt_s.op = rbx_decode(instr_i);
					nxt_s.pc = s_ff.pc + `RBX_PC_W'(2);
					nxt_s.taken = 1'b0;
					nxt_s.q = `RBX_Q2;
				end
			end
			`RBX_Q2: begin
				// Literal is held in the word; a bit set issues its read.
				if (s_ff.op == RBX_OP_SETB) begin
					nxt_s.file.addr = rbx_faddr(s_ff.ir,
					                  bank_select_register_i);
					nxt_s.file.re = 1'b1;
				end
				nxt_s.q = `RBX_Q3;
			end
			`RBX_Q3: begin
				// Compute the target and the modified data byte.
				nxt_s.tgt = s_ff.pc + off2;
				nxt_s.taken = cond;
				if (s_ff.op == RBX_OP_SETB) begin
					nxt_s.file.wdata = file_rdata_i | setmask;
					nxt_s.file.re = 1'b0;
				end
				nxt_s.q = `RBX_Q4;
			end
			default: begin
				// Q4: load the counter or write the register back.
				if (s_ff.st == RBX_ST_NOP) begin
					nxt_s.st = RBX_ST_EXEC;
				end else begin
					if (s_ff.taken) begin
						nxt_s.pc = s_ff.tgt;
						nxt_s.st = RBX_ST_NOP;
					end
					if (s_ff.op == RBX_OP_SETB) begin
						nxt_s.file.we = 1'b1;
					end
					if (s_ff.op != RBX_OP_NONE) begin
						nxt_s.count = s_ff.count + 16'h0001;
					end
				end
				nxt_s.q = `RBX_Q1;
			end
		endcase

		// Register slave: one wait state, answer in the cycle after stb.
		if (bus_go) begin
			nxt_s.ack = 1'b1;
			nxt_s.dat = 32'h0000_0000;
			if (wb_adr_i == `RBX_ADDR_CTRL) begin
				nxt_s.dat[`RBX_CTRL_RUN] = s_ff.run;
				if (wb_we_i && wb_sel_i[0]) begin
					nxt_s.run = wb_dat_i[`RBX_CTRL_RUN];
				end
			end else if (wb_adr_i == `RBX_ADDR_STATUS) begin
				nxt_s.dat[`RBX_ST_NOP_BIT] = (s_ff.st == RBX_ST_NOP);
				nxt_s.dat[`RBX_ST_TAKEN] = s_ff.taken;
				nxt_s.dat[`RBX_ST_OP_LSB +: 3] = s_ff.op;
				nxt_s.dat[`RBX_ST_Q_LSB +: 2] = s_ff.q;
			end else if (wb_adr_i == `RBX_ADDR_PC) begin
				nxt_s.dat = pcword;
				// Loading the counter mid-cycle would tear an instruction,
				// so writes only land while the sequencer is stopped.
				if (wb_we_i && !s_ff.run) begin
					nxt_s.pc = pcnew[`RBX_PC_W-1:0];
				end
			end else if (wb_adr_i == `RBX_ADDR_COUNT) begin
				nxt_s.dat[15:0] = s_ff.count;
			end
			// Unmapped offsets read zero and ignore writes.
		end
	end

	// State register; clock enable freezes everything.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '0;
			s_ff.st <= RBX_ST_EXEC;
			s_ff.op <= RBX_OP_NONE;
			s_ff.run <= `RBX_CTRL_RST;
			s_ff.pc <= `RBX_PC_RST;
			s_ff.q <= `RBX_Q1;
		end else if (ce_i) begin
			s_ff <= nxt_s;
		end
	end

	// All outputs come straight from the state register.
	assign wb_dat_o = s_ff.dat;
	assign wb_ack_o = s_ff.ack;
	assign pc_o = s_ff.pc;
	assign file_o = s_ff.file;
	assign q_phase_o = s_ff.q;

endmodule

// [rbx_exec_properties.sv]
// Port-level assertions for the branch and bit-set executor.
`timescale 1ns/1ns
`include "rbx_regs.svh"
module rbx_exec_chk
	import rbx_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 ce_i,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_ack_o,
	input wire logic [`RBX_PC_W-1:0] pc_o,
	input wire rbx_file_t            file_o,
	input wire logic [7:0]           file_rdata_i,
	input wire logic [1:0]           q_phase_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// The Q4 edge either loads a branch target or leaves the counter alone.
	sequence s_load;
		ce_i && q_phase_o == 2'h3 ##1 ce_i && $changed(pc_o);
	endsequence
	sequence s_step;
		ce_i && q_phase_o == 2'h3 ##1 ce_i && $stable(pc_o);
	endsequence
	chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held too long");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		&& ce_i |=> wb_ack_o) else $error("request not answered");
	chk_phase_order: assert property (ce_i && q_phase_o != 2'h0
		|=> q_phase_o == $past(q_phase_o) + 2'h1) else $error("phase skip");
	chk_pc_quiet: assert property (ce_i && q_phase_o inside {2'h1, 2'h2}
		|=> $stable(pc_o)) else $error("pc moved in Q2 or Q3");
	// A loaded target must survive the flushed cycle's Q1 edge.
	chk_nop_cycle: assert property (s_load |=> $stable(pc_o))
		else $error("fetch in flushed cycle");
	chk_pc_step: assert property (s_step |=> pc_o == $past(pc_o) + 21'h2)
		else $error("pc not stepped by two");
	chk_we_late: assert property ($rose(file_o.we)
		|-> $past(q_phase_o) == 2'h3) else $error("write not after Q4");
	chk_we_pulse: assert property (file_o.we && ce_i |=> !file_o.we)
		else $error("write strobe held");
	chk_read_q3: assert property (file_o.re |-> q_phase_o == 2'h2)
		else $error("read outside Q3");
	// Old bits are kept and at most one new bit is added.
	chk_set_merge: assert property (file_o.re && ce_i |=>
		(file_o.wdata & $past(file_rdata_i)) == $past(file_rdata_i) &&
		$countones(file_o.wdata ^ $past(file_rdata_i)) <= 1)
		else $error("bit set merged wrongly");
endmodule
bind rbx_exec rbx_exec_chk u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .pc_o, .file_o, .file_rdata_i, .q_phase_o);

// [rbx_mem_model.sv]
// Program memory and banked data file on the executor's far side.
`timescale 1ns/1ns
module rbx_mem_model
	import rbx_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [20:0] pc_i,
	output logic      [15:0] instr_o,
	input  wire rbx_file_t   file_i,
	output logic      [7:0]  rdata_o
);
	logic [15:0] pmem [256]; // Program words, wrapping on low pc bits.
	logic [7:0]  fmem [4096]; // Whole banked data space.
	initial foreach (fmem[i]) fmem[i] = 8'h00;
	// Fetch is combinational, so any fetch phase sees the word at pc.
	assign instr_o = pmem[pc_i[8:1]];
	// Without a read strobe the port shows inverted data, never a match.
	assign rdata_o = file_i.re ? fmem[file_i.addr] : ~fmem[file_i.addr];
	// The modified byte lands on the write strobe.
	always @(posedge clk_i) if (file_i.we) fmem[file_i.addr] <= file_i.wdata;
endmodule

// [tb.sv]
// Self-checking bench for the branch and bit-set executor.
`timescale 1ns/1ns
`include "rbx_regs.svh"
module tb
	import rbx_pkg::*;
;
	logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic        wb_we_i = 1'h0, wb_ack_o, ovf_flag_i = 1'h0, mon = 1'h0;
	logic        zero_flag_i = 1'h0, ce_i = 1'h1;
	logic [31:0] cv;
	logic [7:0]  wb_adr_i = 8'h00, file_rdata_i, sh [4096];
	logic [3:0]  bank_select_register_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h12E99F2F;
	logic [31:0] qpc [$], qwr [$], qrd [$];
	logic [20:0] pc_o;
	logic [15:0] instr_i;
	logic [1:0]  q_phase_o;
	rbx_file_t   file_o;
	int          n_fail = 0, checks_done = 0;
	rbx_exec dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .pc_o,
		.instr_i, .ovf_flag_i, .zero_flag_i, .bank_select_register_i, .file_o,
		.file_rdata_i, .q_phase_o);
	rbx_mem_model u_mem (.clk_i, .pc_i(pc_o), .instr_o(instr_i),
		.file_i(file_o), .rdata_o(file_rdata_i));
	always #5 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'h1 && i < 50);
		if (i >= 50) begin
			n_fail++;
			give_verdict();
		end
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	// Random enable gaps while a program runs; each gap freezes a phase.
	always @(posedge clk_i) begin
		cv = rnd();
		ce_i <= !mon || cv[1:0] != 2'h0;
	end
	// Compare each result with the oldest note, once per enabled edge.
	always @(posedge clk_i) begin
		if (ce_i && wb_ack_o && !wb_we_i && qrd.size() > 0)
			chk(wb_dat_o, qrd.pop_front());
		if (ce_i && mon && q_phase_o == `RBX_Q4 && qpc.size() > 0)
			chk(32'(pc_o), qpc.pop_front());
		if (ce_i && mon && file_o.we && qwr.size() > 0)
			chk(32'({file_o.addr, file_o.wdata}), qwr.pop_front());
	end
	// Reset, load a random program, predict its fetches and bit writes.
	task automatic run_prog();
		logic [20:0] p, off;
		logic [31:0] v;
		logic [15:0] w;
		logic [11:0] a;
		logic [5:0]  f;
		int          i;
		v = rnd();
		f = v[5:0];
		@(posedge clk_i);
		rst_i <= 1'h1;
		ovf_flag_i <= f[0];
		zero_flag_i <= f[1];
		bank_select_register_i <= f[5:2];
		@(posedge clk_i);
		rst_i <= 1'h0;
		for (i = 0; i < 256; i++) begin
			v = rnd();
			w = v[15:0];
			if (v[18:17] == 2'h0) w[15:8] = `RBX_OP_BOV;
			if (v[18:17] == 2'h1) w[15:8] = `RBX_OP_BZ;
			if (v[18:17] == 2'h2) w[15:11] = `RBX_OP_BRA;
			if (v[18:17] == 2'h3) w[15:12] = v[19] ? `RBX_OP_BSF : 4'hF;
			// A zero offset would hide the flushed cycle from the pc.
			if (v[18:17] != 2'h3 && w[7:0] == 8'h00) w[7:0] = 8'h80;
			u_mem.pmem[i] = w;
		end
		sh = u_mem.fmem;
		p = {12'h000, v[8:1], 1'h0};
		qrd.push_back(32'h0);
		wb(1'h0, `RBX_ADDR_PC, 32'h0);
		qrd.push_back(32'h0);
		wb(1'h0, `RBX_ADDR_STATUS, 32'h0);
		qrd.push_back(32'h0);
		wb(1'h0, `RBX_ADDR_COUNT, 32'h0);
		wb(1'h1, `RBX_ADDR_PC, 32'(p));
		qrd.push_back(32'(p));
		wb(1'h0, `RBX_ADDR_PC, 32'h0);
		qrd.push_back(32'h0);
		wb(1'h0, 8'h10, 32'h0);
		for (i = 0; i < 30; i++) begin
			w = u_mem.pmem[p[8:1]];
			off = w[15:11] == `RBX_OP_BRA ? 21'(signed'(w[10:0])) :
				21'(signed'(w[7:0]));
			p = p + 21'h2;
			qpc.push_back(32'(p));
			if ((w[15:8] == `RBX_OP_BOV && !f[0]) || w[15:11] == `RBX_OP_BRA ||
				(w[15:8] == `RBX_OP_BZ && !f[1])) begin
				p = p + (off << 1);
				qpc.push_back(32'(p));
			end
			if (w[15:12] == `RBX_OP_BSF) begin
				a = {w[8] ? f[5:2] : (w[7] ? `RBX_ACC_HIBANK : 4'h0), w[7:0]};
				sh[a] = sh[a] | (8'h01 << w[11:9]);
				qwr.push_back(32'({a, sh[a]}));
			end
		end
		mon <= 1'h1;
		wb(1'h1, `RBX_ADDR_CTRL, 32'h1);
		qrd.push_back(32'h1);
		wb(1'h0, `RBX_ADDR_CTRL, 32'h0);
		for (i = 0; i < 1000 && qpc.size() + qwr.size() > 0; i++)
			@(posedge clk_i);
		if (i >= 1000) begin
			n_fail++;
			give_verdict();
		end
		mon <= 1'h0;
		$display("program run done, checks %0d", checks_done);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (4) run_prog();
		give_verdict();
	end
endmodule
